// [shared/plm_cfg.svh]
// register map, field positions, reset values and timing counts of the management port
`ifndef PLM_CFG_SVH
`define PLM_CFG_SVH
`define PLM_OFS_REQ    12'h000
`define PLM_OFS_RES    12'h004
`define PLM_OFS_PARAM  12'h008
`define PLM_OFS_CHAN   12'h00c
`define PLM_OFS_ISTAT  12'h010
`define PLM_OFS_IMASK  12'h014
`define PLM_OFS_EVENT  12'h018
`define PLM_RST_DUPLEX 1'h0
`define PLM_RST_LOOP   2'h0
`define PLM_RST_EXT    3'h0
`define PLM_RST_PREF   4'h0
`define PLM_RST_CHEN   8'hff
`define PLM_RST_TXOUT  1'h1
`define PLM_RST_RXSRC  1'h0
`define PLM_RST_ALOOP  1'h0
`define PLM_MAX_LOOP   4'h2
`define PLM_MAX_EXT    4'h7
`define PLM_MAX_PREF   4'h8
`define PLM_IRQ_DONE   0
`define PLM_IRQ_TERM   1
`define PLM_IRQ_LINE   2
`define PLM_SEQ_CYC    16
`define PLM_BASIC_PRE  2
`define PLM_BASIC_GAP  2
`endif

// [shared/plm_pkg.sv]
// types of the management port: states, operations, result codes, transmit phases
package plm_pkg;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_EXEC = 2'b01,
        ST_DONE = 2'b10
    } plm_state_t;
    typedef enum logic [1:0] {
        OP_RESET = 2'b00,
        OP_SET   = 2'b01,
        OP_GET   = 2'b10,
        OP_BAD   = 2'b11
    } plm_op_t;
    typedef enum logic [1:0] {
        RC_NONE = 2'b00,
        RC_OK   = 2'b01,
        RC_FAIL = 2'b10,
        RC_INV  = 2'b11
    } plm_rc_t;
    typedef enum logic [2:0] {
        TX_IDLE  = 3'b000,
        TX_PREX  = 3'b001,
        TX_PRE   = 3'b010,
        TX_DATA  = 3'b011,
        TX_GAP   = 3'b100
    } plm_txph_t;
endpackage

// [core/plm_mgmt_port.sv]
// management port of a physical-layer entity with apb registers and transmit sequencer
// Behaviour
// [RULE1] reset: no extensions, full duplex, channels enabled
// [RULE2] preamble extension sent before basic preamble
// [RULE3] silent for basic gap plus extension
// [RULE4] one set confirmation after update completes
// [RULE5] client names one defined parameter per read
// [RULE6] read answers failure or in-range value
// [RULE7] faults raise unsolicited events naming item
// [RULE8] management reset equals power-on, then confirms
// [RULE9] reset and events always present
// [RULE10] reset: transmitter on, primary source, loop off
// [RULE11] reset status: ok, failure or invalid; the code reports ok or invalid only, never failure
// [RULE12] set loads each named variable, then confirms
// [RULE13] extensions count zero to seven, zero default
// [RULE14] eight channel enables, preferred none or 1-8
// [RULE15] one to three pairs, status per pair
// [RULE16] client keeps one request outstanding
// [RULE17] bad name or value fails, nothing changes
//
// Decided for this implementation: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "plm_cfg.svh"
module plm_mgmt_port #(
    parameter int SEQ_CYC   = `PLM_SEQ_CYC,
    parameter int BASIC_PRE = `PLM_BASIC_PRE,
    parameter int BASIC_GAP = `PLM_BASIC_GAP
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        term_fault_pin,
    input  wire logic        line_fault_pin,
    input  wire logic        tx_start,
    input  wire logic        tx_stop,
    output logic      [2:0]  tx_phase,
    output logic             half_duplex,
    output logic      [1:0]  loop_mode,
    output logic      [7:0]  tx_ch_en,
    output logic      [7:0]  rx_ch_en,
    output logic      [3:0]  pref_rx_ch,
    output logic             tx_out_en,
    output logic             rx_src_alt,
    output logic             int_loop,
    output logic             mgmt_busy,
    output logic             irq
);
    //----------------------------------------------------------------
    // state
    //----------------------------------------------------------------
    plm_pkg::plm_state_t st_r;
    plm_pkg::plm_txph_t  ph_r;
    logic [31:0] prdata_r;
    logic [27:0] req_r;
    logic [11:0] val_r;
    logic [7:0]  txen_r, rxen_r, div_r;
    logic [5:0]  stat_r;
    logic [4:0]  seq_r;
    logic [3:0]  pref_r;
    logic [2:0]  istat_r, imask_r, pre_r, gap_r, tsy_r, lsy_r;
    logic [1:0]  idx_r, evt_r, loop_r;
    logic        done_r, dup_r, txo_r, rxs_r, alp_r, tog_r, tflt_r, lflt_r;
    logic        pready_r, pslverr_r, irq_r;
    //----------------------------------------------------------------
    // apb decode
    //----------------------------------------------------------------
    wire acc_w   = psel & penable & ~pready_r;
    wire wr_w    = acc_w & pwrite;
    wire hit_req = (paddr == `PLM_OFS_REQ);
    wire hit_res = (paddr == `PLM_OFS_RES);
    wire hit_par = (paddr == `PLM_OFS_PARAM);
    wire hit_chn = (paddr == `PLM_OFS_CHAN);
    wire hit_ist = (paddr == `PLM_OFS_ISTAT);
    wire hit_imk = (paddr == `PLM_OFS_IMASK);
    wire hit_evt = (paddr == `PLM_OFS_EVENT);
    wire mapped  = hit_req | hit_res | hit_par | hit_chn | hit_ist | hit_imk | hit_evt;
    // a request while one is pending is refused with an error
    wire req_go  = wr_w & hit_req & (st_r == plm_pkg::ST_IDLE); // RULE16
    wire req_bsy = wr_w & hit_req & (st_r != plm_pkg::ST_IDLE);
    wire [31:0] par_w = {12'h000, alp_r, 1'b0, rxs_r, txo_r, pref_r, 1'b0, gap_r,
                         1'b0, pre_r, 1'b0, loop_r, dup_r};
    wire [31:0] res_w = {4'h0, req_r[1:0], mgmt_busy, done_r, 4'h0, val_r, 2'h0, stat_r};
    wire [31:0] rd_w  = hit_req ? {4'h0, req_r} :
                        hit_res ? res_w :
                        hit_par ? par_w :
                        hit_chn ? {16'h0000, rxen_r, txen_r} :
                        hit_ist ? {29'h0, istat_r} :
                        hit_imk ? {29'h0, imask_r} :
                        hit_evt ? {30'h0, evt_r} : 32'h0000_0000;

    // answer one cycle into the access phase
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h0000_0000;
        end else begin
            pready_r  <= acc_w;
            pslverr_r <= acc_w & (~mapped | req_bsy);
            prdata_r  <= (acc_w & ~pwrite) ? rd_w : 32'h0000_0000;
        end
    end

    //----------------------------------------------------------------
    // request slot decode and checks
    //----------------------------------------------------------------
    plm_pkg::plm_op_t op_w;
    assign op_w = plm_pkg::plm_op_t'(req_r[1:0]);
    wire [1:0] cnt_w  = req_r[3:2];
    wire [7:0] slot_w = (idx_r == 2'h0) ? req_r[11:4] :
                        (idx_r == 2'h1) ? req_r[19:12] : req_r[27:20];
    wire [3:0] var_w  = slot_w[3:0];
    wire [3:0] nv_w   = slot_w[7:4];
    // every value is checked against the range of its variable, one nibble per variable
    wire known_w = (var_w <= 4'hb); // RULE5
    wire [63:0] max_w = {16'h0000, 16'hffff, 4'h1, 4'h2, 4'h1, `PLM_MAX_PREF,
                         `PLM_MAX_EXT, `PLM_MAX_EXT, `PLM_MAX_LOOP, 4'h1};
    wire ok_w = known_w & (nv_w <= max_w[{var_w, 2'b00} +: 4]); // RULE13 RULE14 RULE17
    wire [63:0] all_w = {16'h0000, rxen_r, txen_r, 3'h0, alp_r, 3'h0, rxs_r, 3'h0, txo_r,
                         pref_r, 1'h0, gap_r, 1'h0, pre_r, 2'h0, loop_r, 3'h0, dup_r};
    wire [3:0] cur_w = all_w[{var_w, 2'b00} +: 4]; // RULE6
    wire in_exec = (st_r == plm_pkg::ST_EXEC);
    wire bad_hdr = (op_w == plm_pkg::OP_BAD) |
                   ((op_w == plm_pkg::OP_RESET) & (cnt_w != 2'h0)) |
                   ((op_w != plm_pkg::OP_RESET) & (cnt_w == 2'h0)); // RULE11 RULE15
    wire do_rst  = in_exec & ~bad_hdr & (op_w == plm_pkg::OP_RESET); // RULE8
    wire do_set  = in_exec & ~bad_hdr & (op_w == plm_pkg::OP_SET) & ok_w; // RULE12
    wire do_get  = in_exec & ~bad_hdr & (op_w == plm_pkg::OP_GET);
    wire last_w  = bad_hdr | (op_w == plm_pkg::OP_RESET) | (idx_r == cnt_w - 2'h1);
    wire [1:0] rc_w = bad_hdr ? plm_pkg::RC_INV :
                      (op_w == plm_pkg::OP_RESET) ? plm_pkg::RC_OK :
                      (op_w == plm_pkg::OP_SET) ? (ok_w ? plm_pkg::RC_OK : plm_pkg::RC_FAIL) :
                      (known_w ? plm_pkg::RC_OK : plm_pkg::RC_FAIL);
    wire [5:0] rcm_w = {4'h0, rc_w} << {idx_r, 1'b0};
    wire [11:0] vm_w = {8'h00, (do_get & known_w) ? cur_w : 4'h0} << {idx_r, 2'b00};

    //----------------------------------------------------------------
    // request sequencer: one slot per cycle, confirm after last
    //----------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r   <= plm_pkg::ST_IDLE;
            req_r  <= 28'h0;
            idx_r  <= 2'h0;
            stat_r <= 6'h00;
            val_r  <= 12'h000;
            done_r <= 1'b0;
        end else begin
            case (st_r)
                plm_pkg::ST_IDLE: begin
                    if (req_go) begin
                        st_r   <= plm_pkg::ST_EXEC;
                        req_r  <= pwdata[27:0];
                        idx_r  <= 2'h0;
                        stat_r <= 6'h00;
                        val_r  <= 12'h000;
                        done_r <= 1'b0;
                    end
                end
                plm_pkg::ST_EXEC: begin
                    stat_r <= stat_r | rcm_w; // RULE15
                    val_r  <= val_r | vm_w;
                    idx_r  <= idx_r + 2'h1;
                    if (last_w) begin
                        st_r <= plm_pkg::ST_DONE;
                    end
                end
                plm_pkg::ST_DONE: begin
                    done_r <= 1'b1; // RULE4
                    st_r   <= plm_pkg::ST_IDLE;
                end
                default: st_r <= plm_pkg::ST_IDLE;
            endcase
        end
    end

    //----------------------------------------------------------------
    // operating parameters
    //----------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dup_r  <= `PLM_RST_DUPLEX;
            loop_r <= `PLM_RST_LOOP;
            pre_r  <= `PLM_RST_EXT;
            gap_r  <= `PLM_RST_EXT;
            pref_r <= `PLM_RST_PREF;
            txen_r <= `PLM_RST_CHEN;
            rxen_r <= `PLM_RST_CHEN;
            txo_r  <= `PLM_RST_TXOUT;
            rxs_r  <= `PLM_RST_RXSRC;
            alp_r  <= `PLM_RST_ALOOP;
        end else if (do_rst) begin // RULE1 RULE8 RULE10
            dup_r  <= `PLM_RST_DUPLEX;
            loop_r <= `PLM_RST_LOOP;
            pre_r  <= `PLM_RST_EXT;
            gap_r  <= `PLM_RST_EXT;
            pref_r <= `PLM_RST_PREF;
            txen_r <= `PLM_RST_CHEN;
            rxen_r <= `PLM_RST_CHEN;
            txo_r  <= `PLM_RST_TXOUT;
            rxs_r  <= `PLM_RST_RXSRC;
            alp_r  <= `PLM_RST_ALOOP;
        end else if (do_set) begin
            case (var_w)
                4'h0: dup_r  <= nv_w[0];
                4'h1: loop_r <= nv_w[1:0];
                4'h2: pre_r  <= nv_w[2:0];
                4'h3: gap_r  <= nv_w[2:0];
                4'h4: pref_r <= nv_w;
                4'h5: txo_r  <= nv_w[0];
                4'h6: rxs_r  <= nv_w[1] ? tog_r : nv_w[0]; // random resolves to a or b
                4'h7: alp_r  <= nv_w[0];
                4'h8: txen_r[3:0] <= nv_w;
                4'h9: txen_r[7:4] <= nv_w;
                4'ha: rxen_r[3:0] <= nv_w;
                4'hb: rxen_r[7:4] <= nv_w;
                default: dup_r <= dup_r;
            endcase
        end
    end

    //----------------------------------------------------------------
    // fault pins: three-stage sync, change once stages two and three agree
    //----------------------------------------------------------------
    wire t_rise = (tsy_r[1] == tsy_r[2]) & tsy_r[2] & ~tflt_r;
    wire l_rise = (lsy_r[1] == lsy_r[2]) & lsy_r[2] & ~lflt_r;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tsy_r  <= 3'h0;
            lsy_r  <= 3'h0;
            tflt_r <= 1'b0;
            lflt_r <= 1'b0;
            tog_r  <= 1'b0;
        end else begin
            tsy_r  <= {tsy_r[1:0], term_fault_pin};
            lsy_r  <= {lsy_r[1:0], line_fault_pin};
            tflt_r <= (tsy_r[1] == tsy_r[2]) ? tsy_r[2] : tflt_r;
            lflt_r <= (lsy_r[1] == lsy_r[2]) ? lsy_r[2] : lflt_r;
            tog_r  <= ~tog_r;
        end
    end

    //----------------------------------------------------------------
    // interrupt status (write one to clear, set wins) and mask
    //----------------------------------------------------------------
    wire [2:0] iset_w = {l_rise, t_rise, (st_r == plm_pkg::ST_DONE)}; // RULE7 RULE9
    wire [2:0] iclr_w = (wr_w & hit_ist) ? pwdata[2:0] : 3'h0;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            istat_r <= 3'h0;
            imask_r <= 3'h0;
            evt_r   <= 2'h0;
            irq_r   <= 1'b0;
        end else begin
            istat_r <= (istat_r & ~iclr_w) | iset_w;
            imask_r <= (wr_w & hit_imk) ? pwdata[2:0] : imask_r;
            evt_r   <= l_rise ? 2'h2 : (t_rise ? 2'h1 : evt_r); // RULE7
            irq_r   <= |(((istat_r & ~iclr_w) | iset_w) & imask_r);
        end
    end

    //----------------------------------------------------------------
    // transmit sequencer: extension, basic preamble, data, gap
    //----------------------------------------------------------------
    wire tick_w = (div_r == 8'(SEQ_CYC - 1));
    wire seq_end = tick_w & (seq_r == 5'h1);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ph_r  <= plm_pkg::TX_IDLE;
            div_r <= 8'h00;
            seq_r <= 5'h00;
        end else if (do_rst) begin
            ph_r  <= plm_pkg::TX_IDLE;
            div_r <= 8'h00;
            seq_r <= 5'h00;
        end else begin
            div_r <= (tick_w | (ph_r == plm_pkg::TX_IDLE)) ? 8'h00 : div_r + 8'h01;
            seq_r <= tick_w ? seq_r - 5'h01 : seq_r;
            case (ph_r)
                plm_pkg::TX_IDLE: begin
                    if (tx_start) begin
                        ph_r  <= (pre_r != 3'h0) ? plm_pkg::TX_PREX : plm_pkg::TX_PRE;
                        seq_r <= (pre_r != 3'h0) ? {2'h0, pre_r} : 5'(BASIC_PRE); // RULE2
                    end
                end
                plm_pkg::TX_PREX: begin
                    if (seq_end) begin
                        ph_r  <= plm_pkg::TX_PRE; // RULE2
                        seq_r <= 5'(BASIC_PRE);
                    end
                end
                plm_pkg::TX_PRE: begin
                    if (seq_end) begin
                        ph_r <= plm_pkg::TX_DATA;
                    end
                end
                plm_pkg::TX_DATA: begin
                    if (tx_stop) begin
                        ph_r  <= plm_pkg::TX_GAP;
                        div_r <= 8'h00;
                        seq_r <= 5'(BASIC_GAP) + {2'h0, gap_r}; // RULE3
                    end
                end
                plm_pkg::TX_GAP: begin
                    if (seq_end) begin
                        ph_r <= plm_pkg::TX_IDLE;
                    end
                end
                default: ph_r <= plm_pkg::TX_IDLE;
            endcase
        end
    end

    //----------------------------------------------------------------
    // outputs
    //----------------------------------------------------------------
    assign prdata      = prdata_r;
    assign pready      = pready_r;
    assign pslverr     = pslverr_r;
    assign tx_phase    = ph_r;
    assign half_duplex = dup_r;
    assign loop_mode   = loop_r;
    assign tx_ch_en    = txen_r;
    assign rx_ch_en    = rxen_r;
    assign pref_rx_ch  = pref_r;
    assign tx_out_en   = txo_r;
    assign rx_src_alt  = rxs_r;
    assign int_loop    = alp_r;
    assign mgmt_busy   = (st_r != plm_pkg::ST_IDLE);
    assign irq         = irq_r;
    //----------------------------------------------------------------
    // checks
    //----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_confirm;
        (st_r == plm_pkg::ST_DONE) ##1 (done_r && istat_r[0]);
    endsequence
    a_confirm_bound: assert property (req_go |=> ##[1:3] s_confirm) // RULE4
        else $error("confirmation missing after request");
    a_reset_state: assert property (do_rst |=> (par_w == 32'h0001_0000) && // RULE8
                                    txen_r == 8'hff && rxen_r == 8'hff && ph_r == 3'h0)
        else $error("management reset did not restore power-on state");
    a_bad_keeps: assert property (in_exec && op_w == plm_pkg::OP_SET && !ok_w // RULE17
                                  |=> $stable(par_w) && $stable({txen_r, rxen_r}))
        else $error("rejected set changed a parameter");
    a_range_held: assert property (pref_r <= 4'h8 && loop_r != 2'h3) // RULE14
        else $error("parameter outside its range");
    a_prex_order: assert property (ph_r == plm_pkg::TX_PREX && !do_rst // RULE2
                                   |=> ph_r == plm_pkg::TX_PREX || ph_r == plm_pkg::TX_PRE)
        else $error("extension not followed by basic preamble");
    a_gap_load: assert property (ph_r == plm_pkg::TX_DATA && tx_stop && !do_rst // RULE3
                                 |=> ph_r == plm_pkg::TX_GAP &&
                                 seq_r == 5'(BASIC_GAP) + {2'h0, $past(gap_r)})
        else $error("gap length not basic plus extension");
    a_event_flag: assert property (t_rise |=> istat_r[1] && evt_r != 2'h0) // RULE7
        else $error("terminal fault event lost");
    a_set_status: assert property (in_exec && !bad_hdr && op_w == plm_pkg::OP_SET // RULE15
                                   |=> (stat_r & $past(rcm_w)) == $past(rcm_w))
        else $error("per-pair status not recorded");
    a_reset_code: assert property (in_exec && bad_hdr |=> stat_r[1:0] == 2'h3) // RULE11
        else $error("invalid request not flagged");
endmodule // plm_mgmt_port
`default_nettype wire

// [verification/plm_client.sv]
// management client model: apb master issuing one request at a time
`timescale 1ns/1ps
`default_nettype none
`include "plm_cfg.svh"
module plm_client (
    input  wire logic        clk,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic      [11:0] paddr,
    output logic      [31:0] pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    // bus idle at time zero
    initial begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 12'h000;
        pwdata  = 32'h0000_0000;
    end
    // setup, then access held until pready is sampled high; released address and data lines show inverse
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic err);
        @(posedge clk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        paddr   <= ~a;
        pwdata  <= ~d;
    endtask
    // write a request word, then poll the result word until done
    task automatic request(input logic [31:0] w, output logic [31:0] res);
        logic e;
        xfer(1'b1, `PLM_OFS_REQ, w, res, e);
        res = 32'h0000_0000;
        for (int i = 0; i < 40 && res[24] !== 1'b1; i++) begin
            xfer(1'b0, `PLM_OFS_RES, 32'h0000_0000, res, e);
        end
    endtask
endmodule // plm_client
`default_nettype wire

// [verification/tb_phy_layer_management_port.sv]
// self-checking bench of the management port against an integer reference model
`timescale 1ns/1ps
`default_nettype none
`include "plm_cfg.svh"
module tb_phy_layer_management_port;
    localparam int SEQ = 2;
    localparam int BPRE = 1;
    localparam int BGAP = 1;
    logic clk, rst_n, psel, penable, pwrite, pready, pslverr, irq, mgmt_busy;
    logic term_fault_pin, line_fault_pin, tx_start, tx_stop, half_duplex;
    logic tx_out_en, rx_src_alt, int_loop;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rnd, q;
    logic [7:0]  tx_ch_en, rx_ch_en;
    logic [3:0]  pref_rx_ch;
    logic [2:0]  tx_phase;
    logic [1:0]  loop_mode;
    logic        e;
    int n_mismatch = 0;
    int num_checks = 0;
    int m[12] = '{0, 0, 0, 0, 0, 1, 0, 0, 15, 15, 15, 15};
    int mx[12] = '{1, 2, 7, 7, 8, 1, 2, 1, 15, 15, 15, 15};

    plm_mgmt_port #(.SEQ_CYC(SEQ), .BASIC_PRE(BPRE), .BASIC_GAP(BGAP)) plm_mgmt_port_inst (
        .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .term_fault_pin(term_fault_pin), .line_fault_pin(line_fault_pin),
        .tx_start(tx_start), .tx_stop(tx_stop), .tx_phase(tx_phase),
        .half_duplex(half_duplex), .loop_mode(loop_mode), .tx_ch_en(tx_ch_en),
        .rx_ch_en(rx_ch_en), .pref_rx_ch(pref_rx_ch), .tx_out_en(tx_out_en),
        .rx_src_alt(rx_src_alt), .int_loop(int_loop), .mgmt_busy(mgmt_busy), .irq(irq));
    plm_client plm_client_inst (
        .clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

    // ----------------------------------------------------------------
    // helpers: comparison, reference model, request runner
    // ----------------------------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic rd(input logic [11:0] a, input string nm, input logic [31:0] exp);
        plm_client_inst.xfer(1'b0, a, 32'h0000_0000, q, e);
        chk(nm, exp, q);
    endtask
    // parameter and channel words from the model, read back and seen at the pins
    task automatic chk_model();
        logic [31:0] pw;
        pw = 32'(m[0] + m[1] * 2 + m[2] * 16 + m[3] * 256 + m[4] * 4096 + m[5] * 65536
                 + m[6] * 131072 + m[7] * 524288);
        rd(`PLM_OFS_PARAM, "param", pw);
        rd(`PLM_OFS_CHAN, "chan", 32'(m[8] + m[9] * 16 + m[10] * 256 + m[11] * 4096));
        chk("pins", pw & 32'h000b_f007, {12'h000, int_loop, 1'b0, rx_src_alt, tx_out_en,
            pref_rx_ch, 9'h000, loop_mode, half_duplex});
        chk("chan pins", 32'(m[8] + m[9] * 16 + m[10] * 256 + m[11] * 4096),
            {16'h0000, rx_ch_en, tx_ch_en});
    endtask
    task automatic do_req(input int op, input int cnt, input int v[3], input int d[3]);
        logic [31:0] w, r;
        int st, vals, vm;
        w = 32'(op + cnt * 4);
        st = 0;
        vals = 0;
        vm = 0;
        for (int k = 0; k < cnt; k++) w = w | (32'(v[k] + d[k] * 16) << (4 + 8 * k));
        plm_client_inst.request(w, r);
        if (op == 0 && cnt == 0) begin
            st = 1;
            m = '{0, 0, 0, 0, 0, 1, 0, 0, 15, 15, 15, 15};
        end else if (op == 0 || op == 3 || cnt == 0) st = 3;
        else for (int k = 0; k < cnt; k++) begin
            if (v[k] > 11 || (op == 1 && d[k] > mx[v[k]])) st += 2 << (2 * k);
            else begin
                st += 1 << (2 * k);
                vm += 15 << (4 * k);
                if (op == 1) m[v[k]] = d[k];
                else vals += m[v[k]] << (4 * k);
            end
        end
        chk("status", 32'(st), {26'h0, r[5:0]});
        chk("result hdr", 32'(op * 4 + 1), {28'h0, r[27:24]});
        chk("busy", 32'h0, {31'h0, mgmt_busy});
        if (op == 2) chk("values", 32'(vals), {20'h0, r[19:8]} & 32'(vm));
        chk_model();
    endtask
    // one transmission: run lengths of every phase are counted
    task automatic tx_run();
        int cnt[8];
        int first;
        cnt = '{default: 0};
        first = 0;
        @(posedge clk);
        tx_start <= 1'b1;
        repeat (120) begin
            @(posedge clk);
            tx_start <= 1'b0;
            tx_stop  <= (cnt[3] == 3);
            cnt[tx_phase]++;
            if (first == 0) first = int'(tx_phase);
        end
        chk("first phase", 32'(m[2] > 0 ? 1 : 2), 32'(first));
        chk("prex len", 32'(m[2] * SEQ), 32'(cnt[1]));
        chk("pre len", 32'(BPRE * SEQ), 32'(cnt[2]));
        chk("gap len", 32'((BGAP + m[3]) * SEQ), 32'(cnt[4]));
    endtask
    task automatic wrap_up();
        if (n_mismatch == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // clock, watchdog and main sequence
    // ----------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        wrap_up();
    end
    initial begin
        rst_n = 1'b0;
        term_fault_pin = 1'b0;
        line_fault_pin = 1'b0;
        tx_start = 1'b0;
        tx_stop = 1'b0;
        rnd = lfsr(32'h79f1);
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        chk_model();
        do_req(1, 3, '{2, 3, 1}, '{int'(rnd[2:0] | 3'h1), int'(rnd[6:4]), 2});
        do_req(1, 3, '{8, 11, 6}, '{int'(rnd[11:8]), int'(rnd[15:12]), 1});
        tx_run();
        do_req(1, 3, '{1, 12, 3}, '{3, 1, 8});
        do_req(1, 1, '{4, 0, 0}, '{9, 0, 0});
        do_req(1, 3, '{2, 4, 0}, '{7, 8, 1});
        do_req(1, 3, '{7, 5, 10}, '{1, 0, 5});
        do_req(2, 3, '{2, 4, 9}, '{0, 0, 0});
        do_req(2, 2, '{12, 3, 0}, '{0, 0, 0});
        do_req(1, 0, '{0, 0, 0}, '{0, 0, 0});
        do_req(3, 1, '{0, 0, 0}, '{0, 0, 0});
        do_req(0, 1, '{0, 0, 0}, '{0, 0, 0});
        plm_client_inst.xfer(1'b1, `PLM_OFS_PARAM, 32'hffff_ffff, q, e);
        plm_client_inst.xfer(1'b1, `PLM_OFS_ISTAT, 32'h0000_0007, q, e);
        plm_client_inst.xfer(1'b1, `PLM_OFS_IMASK, 32'h0000_0003, q, e);
        term_fault_pin <= 1'b1;
        repeat (8) @(posedge clk);
        rd(`PLM_OFS_ISTAT, "istat term", 32'h0000_0002);
        rd(`PLM_OFS_EVENT, "event term", 32'h0000_0001);
        line_fault_pin <= 1'b1;
        repeat (8) @(posedge clk);
        rd(`PLM_OFS_EVENT, "event line", 32'h0000_0002);
        chk("irq on", 32'h1, {31'h0, irq});
        plm_client_inst.xfer(1'b1, `PLM_OFS_ISTAT, 32'h0000_0002, q, e);
        rd(`PLM_OFS_ISTAT, "istat line", 32'h0000_0004);
        chk("irq masked", 32'h0, {31'h0, irq});
        plm_client_inst.xfer(1'b1, `PLM_OFS_IMASK, 32'h0000_0001, q, e);
        do_req(0, 0, '{0, 0, 0}, '{0, 0, 0});
        rd(`PLM_OFS_ISTAT, "istat done", 32'h0000_0005);
        chk("irq done", 32'h1, {31'h0, irq});
        plm_client_inst.xfer(1'b0, 12'h01c, 32'h0000_0000, q, e);
        chk("unmapped", 32'h1, {31'h0, e});
        wrap_up();
    end
endmodule // tb_phy_layer_management_port
`default_nettype wire
